/* File: logic/tcc_pkg.sv */
`default_nettype none
package tcc_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_CONTROL_A  = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_B  = 4'h1;
  localparam logic [3:0] ADDR_COUNT      = 4'h2;
  localparam logic [3:0] ADDR_COMPARE_A  = 4'h3;
  localparam logic [3:0] ADDR_COMPARE_B  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK   = 4'h5;
  localparam logic [3:0] ADDR_IRQ_FLAG   = 4'h6;
  localparam logic [3:0] ADDR_ASYNC      = 4'h7;
  localparam logic [3:0] ADDR_POWER      = 4'h8;

  // Field positions
  localparam int CA_MODE_LO   = 0;
  localparam int CA_COM_B_LO  = 4;
  localparam int CA_COM_A_LO  = 6;
  localparam int CB_CS_LO     = 0;
  localparam int CB_MODE_HI   = 3;
  localparam int CB_FORCE_B   = 6;
  localparam int CB_FORCE_A   = 7;
  localparam int FLAG_OVF     = 0;
  localparam int FLAG_MATCH_A = 1;
  localparam int FLAG_MATCH_B = 2;
  localparam int ASYNC_SEL    = 5;
  localparam int POWER_BIT    = 6;
  localparam logic [7:0] CB_STORE_MASK = 8'h0f;

  // Reset values and counter extremes
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BOTTOM     = 8'h00;
  localparam logic [7:0] MAX        = 8'hff;

  // Wave modes
  localparam logic [2:0] MODE_NORMAL    = 3'h0;
  localparam logic [2:0] MODE_PHASE_MAX = 3'h1;
  localparam logic [2:0] MODE_CLEAR     = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX  = 3'h3;
  localparam logic [2:0] MODE_PHASE_A   = 3'h5;
  localparam logic [2:0] MODE_FAST_A    = 3'h7;

  // Compare output modes
  localparam logic [1:0] COM_NONE   = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // Prescaler tap masks, one per nonzero clock select value
  localparam logic [9:0] TAP_DIV1    = 10'h000;
  localparam logic [9:0] TAP_DIV8    = 10'h007;
  localparam logic [9:0] TAP_DIV32   = 10'h01f;
  localparam logic [9:0] TAP_DIV64   = 10'h03f;
  localparam logic [9:0] TAP_DIV128  = 10'h07f;
  localparam logic [9:0] TAP_DIV256  = 10'h0ff;
  localparam logic [9:0] TAP_DIV1024 = 10'h3ff;

  typedef enum logic [1:0] {
    TCC_DIR_UP   = 2'b01,
    TCC_DIR_DOWN = 2'b10
  } tcc_dir_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcc_bus_req_t;

  typedef struct packed {
    logic [7:0] control_a;
    logic [7:0] control_b;
    logic [7:0] count;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [2:0] mask;
    logic [2:0] flag;
    logic       async_sel;
    logic       power;
    logic [9:0] presc;
    tcc_dir_t   dir;
    logic       block;
    logic       wave_a;
    logic       wave_b;
    logic       osc_s1;
    logic       osc_s2;
    logic       osc_s3;
    logic       osc_lvl;
    logic [7:0] rdata;
  } tcc_state_t;

  localparam tcc_state_t STATE_RESET = '{dir: TCC_DIR_UP, default: '0};
endpackage
`default_nettype wire

/* File: logic/tcc_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module tcc_timer (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire tcc_pkg::tcc_bus_req_t bus_req,
  output logic [7:0]                 rdata,
  input  wire logic [2:0]            irq_ack,
  output logic                       irq_overflow,
  output logic                       irq_match_a,
  output logic                       irq_match_b,
  input  wire logic                  osc_pin_in,
  output logic                       osc_pin_out,
  output logic                       wave_out_a,
  output logic                       wave_oe_a,
  output logic                       wave_out_b,
  output logic                       wave_oe_b
);
  tcc_pkg::tcc_state_t st_reg;
  tcc_pkg::tcc_state_t st_next;

  logic [2:0] mode;
  logic [2:0] cs;
  logic [1:0] com_a;
  logic [1:0] com_b;
  logic       pwm;
  logic       phase;
  logic       fast;
  logic [7:0] top;
  logic       at_top;
  logic       at_bottom;
  logic       at_max;
  logic       match_a;
  logic       match_b;
  logic       osc_edge;
  logic       src_edge;
  logic       tick;
  logic       ev_a;
  logic       ev_b;
  logic       ev_ovf;
  logic       restart;
  logic       force_a;
  logic       force_b;
  logic       wr_count;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  function automatic logic [9:0] tap_mask(input logic [2:0] sel);
    case (sel)
      3'h1:    tap_mask = tcc_pkg::TAP_DIV1;
      3'h2:    tap_mask = tcc_pkg::TAP_DIV8;
      3'h3:    tap_mask = tcc_pkg::TAP_DIV32;
      3'h4:    tap_mask = tcc_pkg::TAP_DIV64;
      3'h5:    tap_mask = tcc_pkg::TAP_DIV128;
      3'h6:    tap_mask = tcc_pkg::TAP_DIV256;
      default: tap_mask = tcc_pkg::TAP_DIV1024;
    endcase
  endfunction

  // Next output level of one compare channel
  function automatic logic wave_step(
    input logic                cur,
    input logic [1:0]          com,
    input logic                hit,
    input logic                frc,
    input logic                is_pwm,
    input logic                is_phase,
    input logic                rst_pt,
    input tcc_pkg::tcc_dir_t   d
  );
    logic r;
    r = cur;
    if (!is_pwm) begin
      if (hit || frc) begin
        case (com)
          tcc_pkg::COM_TOGGLE: r = ~cur;
          tcc_pkg::COM_CLEAR:  r = 1'b0;
          tcc_pkg::COM_SET:    r = 1'b1;
          default:             r = cur;
        endcase
      end
    end else if (is_phase) begin
      if (hit && com[1]) begin
        r = (d == tcc_pkg::TCC_DIR_DOWN) ^ com[0];
      end
    end else begin
      if (hit && com[1]) begin
        r = com[0];
      end else if (rst_pt && com[1]) begin
        r = ~com[0];
      end
    end
    wave_step = r;
  endfunction

  always_comb begin
    mode = {st_reg.control_b[tcc_pkg::CB_MODE_HI],
            st_reg.control_a[tcc_pkg::CA_MODE_LO +: 2]};
    cs = st_reg.control_b[tcc_pkg::CB_CS_LO +: 3];
    com_a = st_reg.control_a[tcc_pkg::CA_COM_A_LO +: 2];
    com_b = st_reg.control_a[tcc_pkg::CA_COM_B_LO +: 2];
    pwm = mode[0];
    phase = pwm && !mode[1];
    fast = pwm && mode[1];
    top = ((mode == tcc_pkg::MODE_CLEAR) || (mode == tcc_pkg::MODE_PHASE_A) ||
           (mode == tcc_pkg::MODE_FAST_A)) ? st_reg.cmp_a
                                           : tcc_pkg::MAX;
    at_top = (st_reg.count == top);
    at_bottom = (st_reg.count == tcc_pkg::BOTTOM);
    at_max = (st_reg.count == tcc_pkg::MAX);
    match_a = (st_reg.count == st_reg.cmp_a);
    match_b = (st_reg.count == st_reg.cmp_b);
    // Filtered level moves only when second and third stages agree
    osc_edge = (st_reg.osc_s2 == st_reg.osc_s3) && st_reg.osc_s3 &&
               !st_reg.osc_lvl;
    src_edge = st_reg.async_sel ? osc_edge : 1'b1;
    tick = st_reg.power && (cs != 3'h0) && src_edge &&
           ((st_reg.presc & tap_mask(cs)) == tap_mask(cs));
    ev_a = tick && match_a && !st_reg.block;
    ev_b = tick && match_b && !st_reg.block;
    if (phase) begin
      ev_ovf = tick && at_bottom && (st_reg.dir == tcc_pkg::TCC_DIR_DOWN);
    end else if (fast) begin
      ev_ovf = tick && at_top;
    end else begin
      ev_ovf = tick && at_max;
    end
    restart = fast && tick && at_top;
    wr_count = bus_req.wr && (bus_req.addr == tcc_pkg::ADDR_COUNT);
    force_a = bus_req.wr && (bus_req.addr == tcc_pkg::ADDR_CONTROL_B) &&
              bus_req.wdata[tcc_pkg::CB_FORCE_A] && !pwm;
    force_b = bus_req.wr && (bus_req.addr == tcc_pkg::ADDR_CONTROL_B) &&
              bus_req.wdata[tcc_pkg::CB_FORCE_B] && !pwm;
    flag_set = {ev_b, ev_a, ev_ovf};
    flag_clr = irq_ack;
    if (bus_req.wr && (bus_req.addr == tcc_pkg::ADDR_IRQ_FLAG)) begin
      flag_clr = irq_ack | bus_req.wdata[2:0];
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.osc_s1 = osc_pin_in;
    st_next.osc_s2 = st_reg.osc_s1;
    st_next.osc_s3 = st_reg.osc_s2;
    if (st_reg.osc_s2 == st_reg.osc_s3) begin
      st_next.osc_lvl = st_reg.osc_s3;
    end
    if (src_edge) begin
      st_next.presc = st_reg.presc + 10'h001;
    end

    if (tick) begin
      st_next.block = 1'b0;
      if (phase) begin
        case (st_reg.dir)
          tcc_pkg::TCC_DIR_UP: begin
            if (at_top) begin
              st_next.dir = tcc_pkg::TCC_DIR_DOWN;
              st_next.count = st_reg.count - 8'h01;
            end else begin
              st_next.count = st_reg.count + 8'h01;
            end
          end
          tcc_pkg::TCC_DIR_DOWN: begin
            if (at_bottom) begin
              st_next.dir = tcc_pkg::TCC_DIR_UP;
              st_next.count = st_reg.count + 8'h01;
            end else begin
              st_next.count = st_reg.count - 8'h01;
            end
          end
          default: st_next.dir = tcc_pkg::TCC_DIR_UP;
        endcase
      end else begin
        st_next.dir = tcc_pkg::TCC_DIR_UP;
        if ((fast || (mode == tcc_pkg::MODE_CLEAR)) && at_top) begin
          st_next.count = tcc_pkg::BOTTOM;
        end else begin
          st_next.count = st_reg.count + 8'h01;
        end
      end
      if (pwm && at_top) begin
        st_next.cmp_a = st_reg.buf_a;
        st_next.cmp_b = st_reg.buf_b;
      end
    end

    st_next.wave_a = wave_step(st_reg.wave_a, com_a, ev_a, force_a, pwm,
                               phase, restart, st_reg.dir);
    st_next.wave_b = wave_step(st_reg.wave_b, com_b, ev_b, force_b, pwm,
                               phase, restart, st_reg.dir);
    st_next.flag = (st_reg.flag & ~flag_clr) | flag_set;

    if (bus_req.wr) begin
      case (bus_req.addr)
        tcc_pkg::ADDR_CONTROL_A: st_next.control_a = bus_req.wdata;
        tcc_pkg::ADDR_CONTROL_B: begin
          st_next.control_b = bus_req.wdata & tcc_pkg::CB_STORE_MASK;
        end
        tcc_pkg::ADDR_COUNT: begin
          st_next.count = bus_req.wdata;
          st_next.block = 1'b1;
        end
        tcc_pkg::ADDR_COMPARE_A: begin
          st_next.buf_a = bus_req.wdata;
          if (!pwm) begin
            st_next.cmp_a = bus_req.wdata;
          end
        end
        tcc_pkg::ADDR_COMPARE_B: begin
          st_next.buf_b = bus_req.wdata;
          if (!pwm) begin
            st_next.cmp_b = bus_req.wdata;
          end
        end
        tcc_pkg::ADDR_IRQ_MASK: st_next.mask = bus_req.wdata[2:0];
        tcc_pkg::ADDR_ASYNC: begin
          st_next.async_sel = bus_req.wdata[tcc_pkg::ASYNC_SEL];
        end
        tcc_pkg::ADDR_POWER: begin
          st_next.power = bus_req.wdata[tcc_pkg::POWER_BIT];
        end
        default: st_next.control_a = st_reg.control_a;
      endcase
    end

    st_next.rdata = tcc_pkg::RESET_BYTE;
    if (bus_req.rd) begin
      case (bus_req.addr)
        tcc_pkg::ADDR_CONTROL_A: st_next.rdata = st_reg.control_a;
        tcc_pkg::ADDR_CONTROL_B: st_next.rdata = st_reg.control_b;
        tcc_pkg::ADDR_COUNT:     st_next.rdata = st_reg.count;
        tcc_pkg::ADDR_COMPARE_A: begin
          st_next.rdata = pwm ? st_reg.buf_a : st_reg.cmp_a;
        end
        tcc_pkg::ADDR_COMPARE_B: begin
          st_next.rdata = pwm ? st_reg.buf_b : st_reg.cmp_b;
        end
        tcc_pkg::ADDR_IRQ_MASK:  st_next.rdata = {5'h00, st_reg.mask};
        tcc_pkg::ADDR_IRQ_FLAG:  st_next.rdata = {5'h00, st_reg.flag};
        tcc_pkg::ADDR_ASYNC: begin
          st_next.rdata[tcc_pkg::ASYNC_SEL] = st_reg.async_sel;
        end
        tcc_pkg::ADDR_POWER: begin
          st_next.rdata[tcc_pkg::POWER_BIT] = st_reg.power;
        end
        default: st_next.rdata = tcc_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= tcc_pkg::STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign irq_overflow = st_reg.flag[tcc_pkg::FLAG_OVF] &
                        st_reg.mask[tcc_pkg::FLAG_OVF];
  assign irq_match_a = st_reg.flag[tcc_pkg::FLAG_MATCH_A] &
                       st_reg.mask[tcc_pkg::FLAG_MATCH_A];
  assign irq_match_b = st_reg.flag[tcc_pkg::FLAG_MATCH_B] &
                       st_reg.mask[tcc_pkg::FLAG_MATCH_B];
  assign osc_pin_out = ~st_reg.osc_lvl;
  // Port override whenever a compare output mode is chosen
  assign wave_out_a = st_reg.wave_a & (com_a != tcc_pkg::COM_NONE);
  assign wave_oe_a = (com_a != tcc_pkg::COM_NONE);
  assign wave_out_b = st_reg.wave_b & (com_b != tcc_pkg::COM_NONE);
  assign wave_oe_b = (com_b != tcc_pkg::COM_NONE);

  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_cpu_write_wins: assert property (
    wr_count |=> (st_reg.count == $past(bus_req.wdata)))
    else $error("count write lost");

  chk_stopped_hold: assert property (
    (cs == 3'h0) && !wr_count |=> $stable(st_reg.count))
    else $error("count moved while stopped");

  chk_power_gate: assert property (
    !st_reg.power && !wr_count |=> $stable(st_reg.count))
    else $error("count moved while powered down");

  chk_match_flag_a: assert property (
    tick && match_a && !st_reg.block && !irq_ack[1]
    |=> st_reg.flag[tcc_pkg::FLAG_MATCH_A])
    else $error("match A flag not set");

  chk_write_blocks: assert property (
    wr_count ##1 (tick && !st_reg.flag[tcc_pkg::FLAG_MATCH_A])
    |=> !st_reg.flag[tcc_pkg::FLAG_MATCH_A])
    else $error("match not blocked after count write");

  chk_normal_wrap: assert property (
    (mode == tcc_pkg::MODE_NORMAL) && tick && at_max && !wr_count &&
    !irq_ack[0]
    |=> (st_reg.count == tcc_pkg::BOTTOM) && st_reg.flag[tcc_pkg::FLAG_OVF])
    else $error("normal wrap or overflow wrong");

  chk_normal_step: assert property (
    (mode == tcc_pkg::MODE_NORMAL) && tick && !at_max && !wr_count
    |=> st_reg.count == $past(st_reg.count) + 8'h01)
    else $error("normal count did not step by one");

  chk_clear_on_match: assert property (
    (mode == tcc_pkg::MODE_CLEAR) && tick && match_a && !wr_count
    |=> st_reg.count == tcc_pkg::BOTTOM)
    else $error("clear on match failed");

  chk_zero_write_keeps: assert property (
    bus_req.wr && (bus_req.addr == tcc_pkg::ADDR_IRQ_FLAG) &&
    (bus_req.wdata[2:0] == 3'h0) && (irq_ack == 3'h0)
    |=> (st_reg.flag & $past(st_reg.flag)) == $past(st_reg.flag))
    else $error("flag lost on zero write");

  chk_flag_clear: assert property (
    bus_req.wr && (bus_req.addr == tcc_pkg::ADDR_IRQ_FLAG) &&
    bus_req.wdata[tcc_pkg::FLAG_MATCH_A] && !ev_a
    |=> !st_reg.flag[tcc_pkg::FLAG_MATCH_A])
    else $error("flag not cleared by one");

  chk_buffer_hold: assert property (
    pwm && !(tick && at_top) && !bus_req.wr
    |=> $stable(st_reg.cmp_a))
    else $error("buffered compare loaded off top");
endmodule
`default_nettype wire

/* File: logic/unused_placeholder_none.sv */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* File: verif/tcc_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module tcc_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       osc_en,
  input  wire logic       svc_en,
  input  wire logic       irq_overflow,
  input  wire logic       irq_match_a,
  input  wire logic       irq_match_b,
  output logic            osc_pin_in,
  output logic [2:0]      irq_ack
);
  // Slow crystal, held low while disabled
  initial begin
    osc_pin_in = 1'b0;
    // Offset keeps pin edges off the rising clock edge
    #20;
    forever begin
      #350;
      osc_pin_in = osc_en ? ~osc_pin_in : 1'b0;
    end
  end

  // One-cycle service acknowledge per raised request
  always_ff @(posedge clk) begin
    if (rst || !svc_en) begin
      irq_ack <= 3'h0;
    end else begin
      irq_ack <= {irq_match_b, irq_match_a, irq_overflow} & ~irq_ack;
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb_timer2_counter_compare_core.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_timer2_counter_compare_core;
  logic                  clk;
  logic                  rst;
  tcc_pkg::tcc_bus_req_t bus_req;
  logic [7:0]            rdata;
  logic [2:0]            irq_ack;
  logic                  irq_overflow;
  logic                  irq_match_a;
  logic                  irq_match_b;
  logic                  osc_pin_in;
  logic                  wave_out_a;
  logic                  wave_oe_a;
  logic                  osc_pin_out;
  logic                  wave_out_b;
  logic                  wave_oe_b;
  logic                  osc_en;
  logic                  svc_en;
  int                    fail_count;
  int                    tests_run;
  int                    cyc;
  int                    guard;
  logic [7:0]            v;
  logic [7:0]            w;

  tcc_timer i_dut (
    .clk          (clk),
    .rst          (rst),
    .bus_req      (bus_req),
    .rdata        (rdata),
    .irq_ack      (irq_ack),
    .irq_overflow (irq_overflow),
    .irq_match_a  (irq_match_a),
    .irq_match_b  (irq_match_b),
    .osc_pin_in   (osc_pin_in),
    .osc_pin_out  (osc_pin_out),
    .wave_out_a   (wave_out_a),
    .wave_oe_a    (wave_oe_a),
    .wave_out_b   (wave_out_b),
    .wave_oe_b    (wave_oe_b)
  );

  tcc_cpu_model i_cpu (
    .clk          (clk),
    .rst          (rst),
    .osc_en       (osc_en),
    .svc_en       (svc_en),
    .irq_overflow (irq_overflow),
    .irq_match_a  (irq_match_a),
    .irq_match_b  (irq_match_b),
    .osc_pin_in   (osc_pin_in),
    .irq_ack      (irq_ack)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    guard <= guard + 1;
    if (guard == 40000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '{default: '0};
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '{default: '0};
    #1;
    d = rdata;
  endtask

  task automatic chk(input string n, input logic [7:0] s,
                     input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rc(input logic [3:0] a, input logic [7:0] e,
                    input string n);
    rd(a, v);
    chk(n, v, e);
  endtask

  initial begin
    bus_req = '{default: '0};
    rst = 1'b1;
    osc_en = 1'b0;
    svc_en = 1'b0;
    fail_count = 0;
    tests_run = 0;
    guard = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rc(tcc_pkg::ADDR_COUNT, 8'h00, "count reset");
    rc(tcc_pkg::ADDR_IRQ_FLAG, 8'h00, "flags reset");
    chk("osc out idle", {7'h00, osc_pin_out}, 8'h01);
    wr(4'hf, 8'h5a);
    rc(4'hf, 8'h00, "unmapped");
    $display("test reset done");

    wr(tcc_pkg::ADDR_CONTROL_B, 8'h01);
    wr(tcc_pkg::ADDR_COUNT, 8'h20);
    repeat (20) @(posedge clk);
    rc(tcc_pkg::ADDR_COUNT, 8'h20, "count unpowered");
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h00);
    wr(tcc_pkg::ADDR_POWER, 8'h40);
    wr(tcc_pkg::ADDR_COUNT, 8'h12);
    repeat (20) @(posedge clk);
    rc(tcc_pkg::ADDR_COUNT, 8'h12, "count stopped");
    $display("test stopped done");

    // Match B on the written value must be swallowed
    wr(tcc_pkg::ADDR_COMPARE_B, 8'hfe);
    wr(tcc_pkg::ADDR_COMPARE_A, 8'hff);
    wr(tcc_pkg::ADDR_COUNT, 8'hfe);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h07);
    v = 8'h00;
    cyc = 0;
    while (v === 8'h00 && cyc < 3000) begin
      rd(tcc_pkg::ADDR_IRQ_FLAG, v);
      cyc++;
    end
    rd(tcc_pkg::ADDR_COUNT, w);
    chk("flags at wrap", v, 8'h03);
    chk("count at wrap", w, 8'h00);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h00);
    wr(tcc_pkg::ADDR_IRQ_FLAG, 8'h00);
    rc(tcc_pkg::ADDR_IRQ_FLAG, 8'h03, "flags kept");
    wr(tcc_pkg::ADDR_IRQ_FLAG, 8'h01);
    rc(tcc_pkg::ADDR_IRQ_FLAG, 8'h02, "ovf cleared");
    wr(tcc_pkg::ADDR_IRQ_MASK, 8'h06);
    repeat (2) @(posedge clk);
    chk("irq a", {7'h00, irq_match_a}, 8'h01);
    chk("irq b", {7'h00, irq_match_b}, 8'h00);
    chk("irq ovf", {7'h00, irq_overflow}, 8'h00);
    svc_en <= 1'b1;
    repeat (6) @(posedge clk);
    rc(tcc_pkg::ADDR_IRQ_FLAG, 8'h00, "serviced");
    chk("irq a off", {7'h00, irq_match_a}, 8'h00);
    svc_en <= 1'b0;
    wr(tcc_pkg::ADDR_IRQ_MASK, 8'h00);
    $display("test normal done");

    wr(tcc_pkg::ADDR_CONTROL_A, 8'h52);
    wr(tcc_pkg::ADDR_COMPARE_A, 8'h03);
    wr(tcc_pkg::ADDR_COUNT, 8'h00);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h80);
    repeat (2) @(posedge clk);
    chk("forced a", {6'h00, wave_oe_a, wave_out_a}, 8'h03);
    chk("forced b", {6'h00, wave_oe_b, wave_out_b}, 8'h02);
    rc(tcc_pkg::ADDR_IRQ_FLAG, 8'h00, "no flag on force");
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h01);
    repeat (40) @(posedge clk);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h00);
    rd(tcc_pkg::ADDR_COUNT, v);
    chk("clear bound", {7'h00, v <= 8'h03}, 8'h01);
    rc(tcc_pkg::ADDR_IRQ_FLAG, 8'h02, "clear match");
    // Count write equal to compare A while ticking every cycle
    wr(tcc_pkg::ADDR_IRQ_FLAG, 8'h07);
    wr(tcc_pkg::ADDR_CONTROL_A, 8'h00);
    wr(tcc_pkg::ADDR_COUNT, 8'h80);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h01);
    wr(tcc_pkg::ADDR_COUNT, 8'h03);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h00);
    rc(tcc_pkg::ADDR_IRQ_FLAG, 8'h00, "match blocked running");
    rc(tcc_pkg::ADDR_COUNT, 8'h05, "count after write");
    $display("test clear done");

    wr(tcc_pkg::ADDR_IRQ_FLAG, 8'h07);
    wr(tcc_pkg::ADDR_CONTROL_A, 8'h00);
    wr(tcc_pkg::ADDR_COMPARE_B, 8'h10);
    wr(tcc_pkg::ADDR_CONTROL_A, 8'h03);
    wr(tcc_pkg::ADDR_COMPARE_B, 8'h20);
    rc(tcc_pkg::ADDR_COMPARE_B, 8'h20, "buffer read");
    wr(tcc_pkg::ADDR_CONTROL_A, 8'h00);
    rc(tcc_pkg::ADDR_COMPARE_B, 8'h10, "active kept");
    wr(tcc_pkg::ADDR_CONTROL_A, 8'h03);
    wr(tcc_pkg::ADDR_COUNT, 8'hfc);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h01);
    repeat (10) @(posedge clk);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h00);
    wr(tcc_pkg::ADDR_CONTROL_A, 8'h00);
    rc(tcc_pkg::ADDR_COMPARE_B, 8'h20, "loaded at top");
    $display("test buffer done");

    wr(tcc_pkg::ADDR_CONTROL_A, 8'h01);
    wr(tcc_pkg::ADDR_COUNT, 8'hf0);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h01);
    repeat (20) @(posedge clk);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h00);
    rd(tcc_pkg::ADDR_COUNT, v);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h01);
    repeat (4) @(posedge clk);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h00);
    rd(tcc_pkg::ADDR_COUNT, w);
    chk("counts down", {7'h00, w < v}, 8'h01);
    $display("test phase done");

    wr(tcc_pkg::ADDR_CONTROL_A, 8'h00);
    wr(tcc_pkg::ADDR_ASYNC, 8'h20);
    wr(tcc_pkg::ADDR_COUNT, 8'h00);
    wr(tcc_pkg::ADDR_CONTROL_B, 8'h01);
    repeat (30) @(posedge clk);
    rc(tcc_pkg::ADDR_COUNT, 8'h00, "no osc no tick");
    osc_en <= 1'b1;
    repeat (140) @(posedge clk);
    osc_en <= 1'b0;
    repeat (10) @(posedge clk);
    rd(tcc_pkg::ADDR_COUNT, v);
    chk("osc ticks", {7'h00, v >= 8'h12 && v <= 8'h16}, 8'h01);
    $display("test async done");
    give_verdict();
  end
endmodule
`default_nettype wire
